// [design/nfh_pkg.sv]
// Package for the NAND flash host controller: command codes, pin timing, op kinds.
// Assumes a 100 MHz core clock and an 8-bit asynchronous NAND part on the far side.
package nfh_pkg;

   // ***************************************
   // Command codes
   // ***************************************
   localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
   localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
   localparam logic [7:0] CMD_READ_COPY    = 8'h35;
   localparam logic [7:0] CMD_PROG_SETUP   = 8'h80;
   localparam logic [7:0] CMD_COPY_PROG    = 8'h85;
   localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
   localparam logic [7:0] CMD_ERASE_CONF   = 8'hd0;
   localparam logic [7:0] CMD_RAND_OUT     = 8'h05;
   localparam logic [7:0] CMD_RAND_OUT_CF  = 8'he0;
   localparam logic [7:0] CMD_RESET        = 8'hff;
   localparam logic [7:0] CMD_STATUS       = 8'h70;
   localparam logic [7:0] CMD_READ_ID      = 8'h90;
   localparam logic [7:0] CMD_ECC_STATUS   = 8'h7a;

   // ***************************************
   // Address layout
   // ***************************************
   localparam int COL_BITS  = 12;
   localparam int ROW_BITS  = 16;
   localparam int ROW_LSB   = 12;
   localparam logic [3:0] COL_HI_PAD = 4'h0;

   // ***************************************
   // Pin timing
   // ***************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int STROBE_LOW_NS = 20;
   localparam int STROBE_HI_NS  = 20;
   localparam int STROBE_LOW_CYC =
      (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_HI_CYC =
      (STROBE_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] STROBE_LOW_CNT = 4'(STROBE_LOW_CYC);
   localparam logic [3:0] STROBE_HI_CNT  = 4'(STROBE_HI_CYC);

   // ***************************************
   // Bus cycle kinds
   // ***************************************
   typedef enum logic [1:0] {
      NFH_CYC_CMD  = 2'h0,
      NFH_CYC_ADDR = 2'h1,
      NFH_CYC_WDAT = 2'h2,
      NFH_CYC_RDAT = 2'h3
   } nfh_cyc_t;

   // ***************************************
   // Operations
   // ***************************************
   typedef enum logic [3:0] {
      NFH_OP_READ      = 4'h0,
      NFH_OP_READ_COPY = 4'h1,
      NFH_OP_PROGRAM   = 4'h2,
      NFH_OP_COPY_PROG = 4'h3,
      NFH_OP_ERASE     = 4'h4,
      NFH_OP_RAND_OUT  = 4'h5,
      NFH_OP_RAND_IN   = 4'h6,
      NFH_OP_RESET     = 4'h7,
      NFH_OP_STATUS    = 4'h8,
      NFH_OP_READ_ID   = 4'h9,
      NFH_OP_ECC_STAT  = 4'ha
   } nfh_op_t;

endpackage

// [design/nfh_cyc_if.sv]
// Interface between the sequencer and the pin-level bus cycle engine.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface nfh_cyc_if;
   import nfh_pkg::*;
   logic       req;
   nfh_cyc_t   kind;
   logic [7:0] wdata;
   logic       done;
   logic [7:0] rdata;
   modport seq (output req, output kind, output wdata, input done, input rdata);
   modport eng (input req, input kind, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// [design/nfh_cycle.sv]
// Pin-level bus cycle engine: one command, address, write or read byte per request.
// Assumes the caller holds chip select low and keeps req high until done.
`timescale 1ns/1ns
`default_nettype none
module nfh_cycle (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic en_i,
   nfh_cyc_if.eng    cyc,
   input  wire logic [7:0] bus_in_i,
   output logic      cmd_latch_o,
   output logic      addr_latch_o,
   output logic      write_strobe_n_o,
   output logic      output_strobe_n_o,
   output logic [7:0] bus_out_o,
   output logic      bus_oe_o
);
   import nfh_pkg::*;

   // ***************************************
   // State
   // ***************************************
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_LOW  = 3'b010,
      S_HIGH = 3'b100
   } nfh_cst_t;

   typedef struct packed {
      nfh_cst_t   st;
      logic [3:0] cnt;
      logic       cle;
      logic       ale;
      logic       we_n;
      logic       re_n;
      logic       oe;
      logic [7:0] dout;
      logic [7:0] rdata;
      logic       done;
   } nfh_cstate_t;

   nfh_cstate_t r;
   nfh_cstate_t next_r;

   // Strobe timing: low phase then high recovery
   always_comb begin
      next_r      = r;
      next_r.done = 1'b0;
      unique case (r.st)
         S_IDLE: begin
            // Skip the done cycle: the caller's req there is still the old one
            if (cyc.req && !r.done) begin
               next_r.st   = S_LOW;
               next_r.cnt  = STROBE_LOW_CNT;
               next_r.cle  = (cyc.kind == NFH_CYC_CMD);
               next_r.ale  = (cyc.kind == NFH_CYC_ADDR);
               next_r.oe   = (cyc.kind != NFH_CYC_RDAT);
               next_r.dout = cyc.wdata;
               // Read falling edge advances the column counter
               next_r.re_n = (cyc.kind != NFH_CYC_RDAT);
               next_r.we_n = (cyc.kind == NFH_CYC_RDAT);
            end
         end
         S_LOW: begin
            if (r.cnt > 4'h1) begin
               next_r.cnt = r.cnt - 4'h1;
            end else begin
               // Write rising edge latches the byte
               next_r.we_n  = 1'b1;
               next_r.re_n  = 1'b1;
               next_r.st    = S_HIGH;
               next_r.cnt   = STROBE_HI_CNT;
            end
         end
         S_HIGH: begin
            if (r.cnt > 4'h1) begin
               next_r.cnt = r.cnt - 4'h1;
            end else begin
               // Read byte taken late, after the two-stage bus sync has settled
               next_r.rdata = bus_in_i;
               next_r.cle  = 1'b0;
               next_r.ale  = 1'b0;
               next_r.oe   = 1'b0;
               next_r.done = 1'b1;
               next_r.st   = S_IDLE;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '{st: S_IDLE, cnt: 4'h0, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                re_n: 1'b1, oe: 1'b0, dout: 8'h00, rdata: 8'h00, done: 1'b0};
      end else if (en_i) begin
         r <= next_r;
      end
   end

   assign cmd_latch_o       = r.cle;
   assign addr_latch_o      = r.ale;
   assign write_strobe_n_o  = r.we_n;
   assign output_strobe_n_o = r.re_n;
   assign bus_out_o         = r.dout;
   assign bus_oe_o          = r.oe;
   assign cyc.done          = r.done;
   assign cyc.rdata         = r.rdata;

   // ***************************************
   // Checks
   // ***************************************
   strobe_width_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      en_i && $fell(r.we_n) |-> !r.we_n [*2])
      else $error("write strobe low too short");
   latch_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      $rose(r.we_n) && r.st == S_HIGH |-> $stable(r.cle) && $stable(r.ale))
      else $error("latch moved at strobe rise");
   no_drive_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !r.re_n |-> !r.oe)
      else $error("host drove bus during read");
endmodule // nfh_cycle
`default_nettype wire

// [design/nfh_host.sv]
// NAND flash host controller: runs whole operations over the flash pins.
// Assumes a 100 MHz clock; ready/busy and read bus come from pins, synchronised here.
`timescale 1ns/1ns
`default_nettype none
module nfh_host #(
   parameter int MAX_LEN = 2112
) (
   input  wire logic               core_clk_i,
   input  wire logic               rst_i,
   input  wire logic               en_i,
   input  wire logic               op_valid_i,
   output logic                    op_ready_o,
   input  wire nfh_pkg::nfh_op_t   op_i,
   input  wire logic [27:0]        op_addr_i,
   input  wire logic [11:0]        op_len_i,
   input  wire logic               wr_valid_i,
   output logic                    wr_ready_o,
   input  wire logic [7:0]         wr_data_i,
   output logic                    rd_valid_o,
   output logic [7:0]              rd_data_o,
   output logic                    op_done_o,
   output logic                    busy_o,
   input  wire logic               write_enable_i,
   output logic                    chip_sel_n_o,
   output logic                    cmd_latch_o,
   output logic                    addr_latch_o,
   output logic                    write_strobe_n_o,
   output logic                    output_strobe_n_o,
   output logic                    write_protect_n_o,
   input  wire logic [7:0]         shared_bus_lines_i,
   output logic [7:0]              shared_bus_lines_o,
   output logic                    shared_bus_lines_oe_o,
   input  wire logic               ready_busy_n_i
);
   import nfh_pkg::*;

   // Length field is 12 bits wide
   if (MAX_LEN < 1 || MAX_LEN > 4095) begin : g_len_chk
      $error("MAX_LEN out of range");
   end

   // ***************************************
   // State
   // ***************************************
   typedef enum logic [5:0] {
      H_IDLE = 6'b000001,
      H_CMD1 = 6'b000010,
      H_ADDR = 6'b000100,
      H_DATA = 6'b001000,
      H_CMD2 = 6'b010000,
      H_WAIT = 6'b100000
   } nfh_hst_t;

   typedef struct packed {
      nfh_hst_t   st;
      nfh_op_t    op;
      logic [27:0] addr;
      logic [11:0] left;
      logic [2:0] aidx;
      logic       ce;
      logic       req;
      logic       rvalid;
      logic [7:0] rdata;
      logic       done;
      logic [1:0] rb_sync;
      logic [7:0] bus_s1;
   } nfh_hstate_t;

   nfh_hstate_t r;
   nfh_hstate_t next_r;
   nfh_cyc_if   cyc ();
   logic        ready;
   logic [7:0]  bus_s2;
   logic [7:0]  first_cmd;
   logic [7:0]  second_cmd;
   logic [2:0]  addr_cnt;
   logic        has_data;
   logic        has_conf;
   logic        is_read;
   logic        blocked;
   logic [7:0]  addr_byte;
   logic        accept;

   // Ready/busy pin synchronised; level stays meaningful when deselected
   assign ready = r.rb_sync[1];

   // Command set per operation, only defined codes
   always_comb begin
      first_cmd  = CMD_RESET;
      second_cmd = CMD_READ_CONFIRM;
      addr_cnt   = 3'd0;
      has_data   = 1'b0;
      has_conf   = 1'b0;
      is_read    = 1'b0;
      unique case (r.op)
         NFH_OP_READ: begin
            first_cmd = CMD_READ_SETUP; second_cmd = CMD_READ_CONFIRM;
            addr_cnt = 3'd4; has_conf = 1'b1;
         end
         NFH_OP_READ_COPY: begin
            first_cmd = CMD_READ_SETUP; second_cmd = CMD_READ_COPY;
            addr_cnt = 3'd4; has_conf = 1'b1;
         end
         NFH_OP_PROGRAM: begin
            first_cmd = CMD_PROG_SETUP; second_cmd = CMD_PROG_CONFIRM;
            addr_cnt = 3'd4; has_data = 1'b1; has_conf = 1'b1;
         end
         NFH_OP_COPY_PROG: begin
            first_cmd = CMD_COPY_PROG; second_cmd = CMD_PROG_CONFIRM;
            addr_cnt = 3'd4; has_data = 1'b1; has_conf = 1'b1;
         end
         NFH_OP_ERASE: begin
            first_cmd = CMD_ERASE_SETUP; second_cmd = CMD_ERASE_CONF;
            addr_cnt = 3'd2; has_conf = 1'b1;
         end
         NFH_OP_RAND_OUT: begin
            first_cmd = CMD_RAND_OUT; second_cmd = CMD_RAND_OUT_CF;
            addr_cnt = 3'd2; has_conf = 1'b1; has_data = 1'b1; is_read = 1'b1;
         end
         NFH_OP_RAND_IN: begin
            first_cmd = CMD_COPY_PROG; addr_cnt = 3'd2; has_data = 1'b1;
         end
         NFH_OP_RESET:    first_cmd = CMD_RESET;
         NFH_OP_STATUS: begin
            first_cmd = CMD_STATUS; has_data = 1'b1; is_read = 1'b1;
         end
         NFH_OP_READ_ID: begin
            first_cmd = CMD_READ_ID; addr_cnt = 3'd1; has_data = 1'b1; is_read = 1'b1;
         end
         NFH_OP_ECC_STAT: begin
            first_cmd = CMD_ECC_STATUS; has_data = 1'b1; is_read = 1'b1;
         end
         default: first_cmd = CMD_RESET;
      endcase
   end

   // Address byte order; erase sends row bytes only
   always_comb begin
      logic [2:0] slot;
      slot = (r.op == NFH_OP_ERASE) ? r.aidx + 3'd2 : r.aidx;
      unique case (slot)
         3'd0:    addr_byte = r.addr[7:0];
         3'd1:    addr_byte = {COL_HI_PAD, r.addr[11:8]};
         3'd2:    addr_byte = r.addr[19:12];
         default: addr_byte = r.addr[27:20];
      endcase
   end

   // While busy only reset and status may start
   assign blocked = !ready && op_i != NFH_OP_RESET && op_i != NFH_OP_STATUS;
   assign accept  = r.st == H_IDLE && op_valid_i && !blocked && en_i;

   // Sequencer
   always_comb begin
      next_r         = r;
      next_r.rb_sync = {r.rb_sync[0], ready_busy_n_i};
      next_r.bus_s1  = shared_bus_lines_i;
      next_r.rvalid  = 1'b0;
      next_r.done    = 1'b0;
      unique case (r.st)
         H_IDLE: begin
            if (accept) begin
               next_r.op   = op_i;
               next_r.addr = op_addr_i;
               next_r.left = op_len_i;
               next_r.aidx = 3'd0;
               next_r.ce   = 1'b1;
               next_r.req  = 1'b1;
               next_r.st   = H_CMD1;
            end
         end
         H_CMD1: begin
            if (cyc.done) begin
               next_r.req = (addr_cnt != 3'd0) || (has_data && r.left != 12'h0) || has_conf;
               next_r.st  = (addr_cnt != 3'd0) ? H_ADDR
                          : (has_data && r.left != 12'h0) ? H_DATA : H_WAIT;
            end
         end
         H_ADDR: begin
            if (cyc.done) begin
               next_r.aidx = r.aidx + 3'd1;
               if (r.aidx + 3'd1 == addr_cnt) begin
                  next_r.req = 1'b0;
                  next_r.st  = (has_conf && is_read) ? H_CMD2
                             : (has_data && r.left != 12'h0) ? H_DATA
                             : has_conf ? H_CMD2 : H_WAIT;
                  next_r.req = next_r.st != H_WAIT;
               end
            end
         end
         H_DATA: begin
            next_r.req = is_read || wr_valid_i;
            if (cyc.done) begin
               next_r.left = r.left - 12'h1;
               if (is_read) begin
                  next_r.rvalid = 1'b1;
                  next_r.rdata  = cyc.rdata;
               end
               if (r.left == 12'h1) begin
                  next_r.st  = (has_conf && !is_read) ? H_CMD2 : H_WAIT;
                  next_r.req = has_conf && !is_read;
               end
            end
         end
         H_CMD2: begin
            if (cyc.done) begin
               next_r.req = is_read && r.left != 12'h0;
               next_r.st  = next_r.req ? H_DATA : H_WAIT;
            end
         end
         H_WAIT: begin
            // Wait for ready before finishing; select held through busy
            next_r.req = 1'b0;
            if (ready) begin
               next_r.ce   = 1'b0;
               next_r.done = 1'b1;
               next_r.st   = H_IDLE;
            end
         end
      endcase
      if (cyc.done) next_r.req = next_r.req && !(r.st == H_DATA && !is_read && !wr_valid_i);
   end

   // State register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '{st: H_IDLE, op: NFH_OP_RESET, addr: 28'h0, left: 12'h0, aidx: 3'd0,
                ce: 1'b0, req: 1'b0, rvalid: 1'b0, rdata: 8'h00, done: 1'b0,
                rb_sync: 2'h0, bus_s1: 8'h00};
      end else if (en_i) begin
         r <= next_r;
      end
   end

   // Second stage of the read bus synchroniser
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) bus_s2 <= 8'h00;
      else if (en_i) bus_s2 <= r.bus_s1;
   end

   // Byte to send for this cycle
   assign cyc.req   = r.req && !(r.st == H_DATA && !is_read && !wr_valid_i);
   assign cyc.kind  = (r.st == H_CMD1 || r.st == H_CMD2) ? NFH_CYC_CMD
                    : (r.st == H_ADDR) ? NFH_CYC_ADDR
                    : is_read ? NFH_CYC_RDAT : NFH_CYC_WDAT;
   assign cyc.wdata = (r.st == H_CMD1) ? first_cmd
                    : (r.st == H_CMD2) ? second_cmd
                    : (r.st == H_ADDR) ? addr_byte : wr_data_i;

   nfh_cycle u_cycle (
      .core_clk_i        (core_clk_i),
      .rst_i             (rst_i),
      .en_i              (en_i),
      .cyc               (cyc),
      .bus_in_i          (bus_s2),
      .cmd_latch_o       (cmd_latch_o),
      .addr_latch_o      (addr_latch_o),
      .write_strobe_n_o  (write_strobe_n_o),
      .output_strobe_n_o (output_strobe_n_o),
      .bus_out_o         (shared_bus_lines_o),
      .bus_oe_o          (shared_bus_lines_oe_o)
   );

   // Outputs
   assign op_ready_o        = r.st == H_IDLE && !blocked;
   assign wr_ready_o        = r.st == H_DATA && !is_read && cyc.done;
   assign rd_valid_o        = r.rvalid;
   assign rd_data_o         = r.rdata;
   assign op_done_o         = r.done;
   assign busy_o            = !ready;
   assign chip_sel_n_o      = !r.ce;
   assign write_protect_n_o = write_enable_i;

   // ***************************************
   // Checks
   // ***************************************
   sequence confirm_sent_s;
      r.st == H_CMD2 && cyc.done;
   endsequence
   busy_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      accept && !ready |-> op_i == NFH_OP_RESET || op_i == NFH_OP_STATUS)
      else $error("command started while busy");
   wait_ready_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      op_done_o |-> $past(ready))
      else $error("operation ended while busy");
   confirm_wait_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (confirm_sent_s and (en_i && !is_read)) |=> r.st == H_WAIT)
      else $error("confirm not followed by wait");
   addr_pad_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      r.st == H_ADDR && r.aidx == 3'd1 && r.op != NFH_OP_ERASE |-> cyc.wdata[7:4] == 4'h0)
      else $error("column high nibble not zero");
   select_held_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !write_strobe_n_o |-> !chip_sel_n_o)
      else $error("write strobe without select");
endmodule // nfh_host
`default_nettype wire

// [tb/nfh_flash_model.sv]
// Behavioural flash device for the host controller bench.
// Assumes the bench resolves the bus and pulls ready/busy up.
`timescale 1ns/1ns
`default_nettype none
module nfh_flash_model #(
   parameter int BUSY_NS = 500,
   parameter int HOLD_NS = 30
) (
   input  wire logic       chip_sel_n_i,
   input  wire logic       cmd_latch_i,
   input  wire logic       addr_latch_i,
   input  wire logic       write_strobe_n_i,
   input  wire logic       output_strobe_n_i,
   input  wire logic       write_protect_n_i,
   input  wire logic       hold_busy_i,
   input  wire logic       host_oe_i,
   input  wire logic [7:0] bus_i,
   output logic [7:0]      bus_o,
   output logic            drive_o,
   output wire logic       ready_busy_n_o
);
   import nfh_pkg::*;
   logic [9:0]  log_q[$];
   logic [11:0] col = 12'h000;
   logic        busy = 1'b0;
   int          viol = 0;
   int          busy_starts = 0;
   int          acnt = 0;
   int          gen = 0;
   initial bus_o = 8'h00;
   initial drive_o = 1'b0;
   // Open drain, low while busy whatever the select
   assign ready_busy_n_o = (busy || hold_busy_i) ? 1'b0 : 1'bz;
   // Busy span after a confirm
   always @(posedge busy) begin
      #(BUSY_NS);
      busy = 1'b0;
   end
   // Byte capture on write strobe rise
   always @(posedge write_strobe_n_i) begin
      if (chip_sel_n_i || !host_oe_i || (cmd_latch_i && addr_latch_i))
         viol++;
      else if (cmd_latch_i) begin
         if ((busy || hold_busy_i) && bus_i != 8'hff && bus_i != 8'h70) viol++;
         acnt = 0;
         log_q.push_back({NFH_CYC_CMD, bus_i});
         if ((write_protect_n_i && bus_i inside {8'h10, 8'hd0}) || bus_i inside {8'h30, 8'h35}) begin
            busy = 1'b1;
            busy_starts++;
         end
      end else if (addr_latch_i) begin
         if (acnt == 0) col[7:0] = bus_i;
         if (acnt == 1) col[11:8] = bus_i[3:0];
         acnt++;
         log_q.push_back({NFH_CYC_ADDR, bus_i});
      end else
         log_q.push_back({NFH_CYC_WDAT, bus_i});
   end
   // Next byte on read strobe fall, column advances
   always @(negedge output_strobe_n_i) if (!chip_sel_n_i) begin
      gen++;
      #1;
      bus_o = col[7:0] ^ 8'h5a;
      drive_o = 1'b1;
      col++;
   end
   // Bus released after hold, shows inverted garbage
   always @(posedge output_strobe_n_i) begin : rel
      int g;
      g = gen;
      #(HOLD_NS);
      if (g == gen) begin
         drive_o = 1'b0;
         bus_o = ~bus_o;
      end
   end
endmodule // nfh_flash_model
`default_nettype wire

// [tb/nfh_host_tb.sv]
// Self-checking bench for the flash host controller.
// Assumes the behavioural device model and the design package.
`timescale 1ns/1ns
`default_nettype none
module nfh_host_tb;
   import nfh_pkg::*;
   logic core_clk = 0, rst = 1, en = 0, op_valid = 0, wr_valid = 0, write_enable = 1, hold_busy = 0;
   nfh_op_t op = NFH_OP_STATUS;
   logic [27:0] op_addr = 28'h0000000;
   logic [11:0] op_len = 12'h000;
   logic [7:0] wr_data = 8'h00, rd_data, host_out, dev_bus, bus_in;
   logic op_ready, wr_ready, rd_valid, op_done, busy, cs_n, cle, ale, we_n, re_n, wp_n, host_oe, dev_oe;
   logic seen_busy = 0;
   wire rb_n;
   int error_cnt = 0, tests_run = 0, seed = 90769;
   logic [7:0] wq[$], rq[$];
   pullup (rb_n);
   assign bus_in = host_oe ? host_out : dev_bus;
   always #5 core_clk = ~core_clk;
   nfh_host #(.MAX_LEN(2112)) i_nfh_host (.core_clk_i(core_clk), .rst_i(rst), .en_i(en),
      .op_valid_i(op_valid), .op_ready_o(op_ready), .op_i(op), .op_addr_i(op_addr), .op_len_i(op_len),
      .wr_valid_i(wr_valid), .wr_ready_o(wr_ready), .wr_data_i(wr_data), .rd_valid_o(rd_valid),
      .rd_data_o(rd_data), .op_done_o(op_done), .busy_o(busy), .write_enable_i(write_enable),
      .chip_sel_n_o(cs_n), .cmd_latch_o(cle), .addr_latch_o(ale), .write_strobe_n_o(we_n),
      .output_strobe_n_o(re_n), .write_protect_n_o(wp_n), .shared_bus_lines_i(bus_in),
      .shared_bus_lines_o(host_out), .shared_bus_lines_oe_o(host_oe), .ready_busy_n_i(rb_n));
   nfh_flash_model i_nfh_flash_model (.chip_sel_n_i(cs_n), .cmd_latch_i(cle), .addr_latch_i(ale),
      .write_strobe_n_i(we_n), .output_strobe_n_i(re_n), .write_protect_n_i(wp_n),
      .hold_busy_i(hold_busy), .host_oe_i(host_oe), .bus_i(bus_in), .bus_o(dev_bus),
      .drive_o(dev_oe), .ready_busy_n_o(rb_n));
   task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("Mismatches %0d, checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Write stream source, byte and read capture, bus clash watch
   always @(posedge core_clk) begin
      if (wr_valid && wr_ready) wq.push_back(wr_data);
      if (wr_valid && wr_ready) wr_data <= 8'($random(seed));
      if (rd_valid) rq.push_back(rd_data);
      if (busy === 1'b1) seen_busy = 1;
      if (host_oe && dev_oe) cmp(10'h001, 10'h000);
   end
   // First and confirm code of each operation, zero for none
   function automatic logic [15:0] codes(input nfh_op_t o);
      case (o)
         NFH_OP_READ:      return 16'h0030;
         NFH_OP_READ_COPY: return 16'h0035;
         NFH_OP_PROGRAM:   return 16'h8010;
         NFH_OP_COPY_PROG: return 16'h8510;
         NFH_OP_ERASE:     return 16'h60d0;
         NFH_OP_RAND_OUT:  return 16'h05e0;
         NFH_OP_RAND_IN:   return 16'h8500;
         NFH_OP_RESET:     return 16'hff00;
         NFH_OP_STATUS:    return 16'h7000;
         NFH_OP_READ_ID:   return 16'h9000;
         default:          return 16'h7a00;
      endcase
   endfunction
   function automatic logic [7:0] ab(input logic [27:0] a, input int i);
      return i == 0 ? a[7:0] : i == 1 ? {4'h0, a[11:8]} : i == 2 ? a[19:12] : a[27:20];
   endfunction
   // One whole operation, then its pin trace against the expected one
   task automatic run_op(input nfh_op_t o, input logic [27:0] a, input logic [11:0] n);
      logic [9:0] e[$];
      logic [15:0] c;
      int t;
      i_nfh_flash_model.log_q.delete();
      wq.delete();
      rq.delete();
      seen_busy = 0;
      c = codes(o);
      op <= o;
      op_addr <= a;
      op_len <= n;
      op_valid <= 1;
      t = 0;
      do begin
         @(posedge core_clk);
         t++;
      end while (op_ready !== 1'b1 && t < 3000);
      op_valid <= 0;
      do begin
         @(posedge core_clk);
         t++;
      end while (op_done !== 1'b1 && t < 6000);
      cmp(10'(t < 6000), 10'h001);
      e.push_back({NFH_CYC_CMD, c[15:8]});
      if (o inside {NFH_OP_READ, NFH_OP_READ_COPY, NFH_OP_PROGRAM, NFH_OP_COPY_PROG})
         for (int i = 0; i < 4; i++) e.push_back({NFH_CYC_ADDR, ab(a, i)});
      if (o == NFH_OP_ERASE) for (int i = 2; i < 4; i++) e.push_back({NFH_CYC_ADDR, ab(a, i)});
      if (o inside {NFH_OP_RAND_OUT, NFH_OP_RAND_IN})
         for (int i = 0; i < 2; i++) e.push_back({NFH_CYC_ADDR, ab(a, i)});
      if (o == NFH_OP_READ_ID) e.push_back({NFH_CYC_ADDR, a[7:0]});
      if (o inside {NFH_OP_PROGRAM, NFH_OP_COPY_PROG, NFH_OP_RAND_IN})
         foreach (wq[i]) e.push_back({NFH_CYC_WDAT, wq[i]});
      if (c[7:0] != 8'h00) e.push_back({NFH_CYC_CMD, c[7:0]});
      cmp(10'(i_nfh_flash_model.log_q.size()), 10'(e.size()));
      foreach (e[i])
         cmp(i < i_nfh_flash_model.log_q.size() ? i_nfh_flash_model.log_q[i] : 10'h3ff, e[i]);
      if (o inside {NFH_OP_READ, NFH_OP_RAND_OUT}) begin
         // Page read only loads the page; its bytes come out by random output
         cmp(10'(rq.size()), 10'(o == NFH_OP_READ ? 12'd0 : n));
         foreach (rq[i]) cmp({2'h0, rq[i]}, {2'h0, 8'(a[11:0] + i) ^ 8'h5a});
      end
      if (o inside {NFH_OP_READ, NFH_OP_PROGRAM, NFH_OP_ERASE}) cmp(10'(seen_busy), 10'(write_enable));
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      // Strobe leaving unknown at reset looks like a write edge to the model
      i_nfh_flash_model.viol = 0;
      rst <= 0;
      en <= 1;
      wr_valid <= 1;
      repeat (3) @(posedge core_clk);
      run_op(NFH_OP_PROGRAM, 28'hffff83f, 12'd1);
      run_op(NFH_OP_READ, 28'hffff83e, 12'd2);
      run_op(NFH_OP_RAND_OUT, 28'hffff83e, 12'd2);
      repeat (3) for (int k = 0; k <= 10; k++)
         run_op(nfh_op_t'(k), {16'($random(seed)), 1'b0, 11'($random(seed))}, 12'(1 + ($random(seed) & 3)));
      write_enable <= 0;
      run_op(NFH_OP_ERASE, 28'h1234000, 12'd0);
      cmp({9'h000, wp_n}, 10'h000);
      write_enable <= 1;
      hold_busy <= 1;
      repeat (4) @(posedge core_clk);
      for (int k = 0; k <= 10; k++) begin
         op <= nfh_op_t'(k);
         @(posedge core_clk);
         cmp({9'h000, op_ready}, 10'(k == 7 || k == 8));
      end
      hold_busy <= 0;
      run_op(NFH_OP_STATUS, 28'h0000000, 12'd1);
      cmp(10'(i_nfh_flash_model.viol), 10'h000);
      stop_test;
   end
   // Watchdog against a hang
   initial begin
      #900000;
      error_cnt++;
      stop_test;
   end
endmodule // nfh_host_tb
`default_nettype wire
